// File: rtl/dls_serializer.sv
// Operation
// - Input word is 21 bits: 18 colour bits plus line, frame, valid.
// - Three differential serial data pairs carry the serialised word.
// - One differential forwarded clock pair runs beside the data.
// - Standby low puts all serial outputs in high impedance.
// - Standby holds the block in reset with the clock generator off.
// - Strobe select high captures inputs on rising pixel clock edge.
// - Strobe select low or open captures on falling pixel clock edge.
// - Clock and data may first appear after standby release.
// - Stopped then resumed clock relocks without cycling standby.
// - Outputs follow spread spectrum input clock and data.
`timescale 1ns/100ps
`default_nettype none
`include "dls_params.svh"
module dls_serializer #(
  parameter int LOST_CYC = `DLS_LOST_CYC
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_I,
  input  wire logic              STANDBY_N_I,
  input  wire logic              STROBE_EDGE_SELECT_I,
  input  wire logic              PIXEL_CLOCK_IN_I,
  input  wire dls_pkg::dls_word_t PARALLEL_PIXEL_IN_I,
  output logic                   IN_READY_O,
  output dls_pkg::dls_lanes_t    SERIAL_DATA_POS_O,
  output dls_pkg::dls_lanes_t    SERIAL_DATA_NEG_O,
  output dls_pkg::dls_lanes_t    SERIAL_DATA_OE_O,
  output logic                   FWD_CLOCK_POS_O,
  output logic                   FWD_CLOCK_NEG_O,
  output logic                   FWD_CLOCK_OE_O,
  output logic                   LOCKED_O
);
  import dls_pkg::*;

  logic       sb_s1, sb_s2;
  logic       sel_s1, sel_s2;
  logic       pclk_s1, pclk_s2, pclk_d;
  dls_word_t  pix_s1, pix_s2;
  logic       blk_rst;
  logic       cap_edge;
  logic [7:0] lost_cnt;
  logic       clk_alive;
  dls_state_t state;
  dls_word_t  shreg;
  logic [2:0] slot;
  logic       fwd;
  logic       in_valid;

  dls_buf_if bq ();

  function automatic logic lane_bit(input dls_word_t w, input int lane,
                                    input logic [2:0] s);
    lane_bit = w[lane*`DLS_BITS_LANE + int'(s)];
  endfunction

  // Two-stage synchronisers for standby, strobe select, pixel clock and pixel inputs
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sb_s1   <= 1'b0;
      sb_s2   <= 1'b0;
      sel_s1  <= 1'b0;
      sel_s2  <= 1'b0;
      pclk_s1 <= 1'b0;
      pclk_s2 <= 1'b0;
      pclk_d  <= 1'b0;
      pix_s1  <= '0;
      pix_s2  <= '0;
    end else begin
      sb_s1   <= STANDBY_N_I;
      sb_s2   <= sb_s1;
      sel_s1  <= STROBE_EDGE_SELECT_I;
      sel_s2  <= sel_s1;
      pclk_s1 <= PIXEL_CLOCK_IN_I;
      pclk_s2 <= pclk_s1;
      pclk_d  <= pclk_s2;
      pix_s1  <= PARALLEL_PIXEL_IN_I;
      pix_s2  <= pix_s1;
    end
  end

  // Standby acts as a reset of the whole data path
  assign blk_rst = RST_I || !sb_s2;

  // Edge choice by strobe select; low is the default level
  assign cap_edge = sel_s2 ? (pclk_s2 && !pclk_d)
                           : (!pclk_s2 && pclk_d);

  // Clock activity watchdog; relocks on its own after a restart
  always_ff @(posedge CORE_CLK_I) begin
    if (blk_rst) begin
      lost_cnt  <= 8'h0;
      clk_alive <= 1'b0;
    end else if (cap_edge) begin
      lost_cnt  <= 8'h0;
      clk_alive <= 1'b1;
    end else if (lost_cnt == 8'(LOST_CYC)) begin
      clk_alive <= 1'b0;
    end else begin
      lost_cnt <= lost_cnt + 8'h1;
    end
  end

  assign in_valid     = cap_edge && clk_alive;
  assign bq.in_valid  = in_valid;
  assign bq.in_data   = pix_s2;
  assign IN_READY_O   = bq.in_ready;

  dls_buf2 #(.DEPTH(2)) u_buf (
    .clk_i (CORE_CLK_I),
    .rst_i (blk_rst),
    .bus   (bq.buf_side)
  );

  // Word is taken when the serialiser finishes its last slot
  assign bq.out_ready = (state == DLS_IDLE) ||
                        (slot == 3'(`DLS_BITS_LANE - 1));

  always_ff @(posedge CORE_CLK_I) begin
    if (blk_rst) begin
      state <= DLS_IDLE;
      shreg <= '0;
      slot  <= 3'h0;
    end else if (bq.out_ready && bq.out_valid) begin
      state <= DLS_RUN;
      shreg <= bq.out_data;
      slot  <= 3'h0;
    end else if (state == DLS_RUN) begin
      if (slot == 3'(`DLS_BITS_LANE - 1)) begin
        state <= DLS_IDLE;
        slot  <= 3'h0;
      end else begin
        slot <= slot + 3'h1;
      end
    end
  end

  // Serial lanes and forwarded clock, both from flops
  always_ff @(posedge CORE_CLK_I) begin
    if (blk_rst) begin
      SERIAL_DATA_POS_O <= '0;
      SERIAL_DATA_NEG_O <= '1;
      fwd               <= 1'b0;
    end else begin
      for (int l = 0; l < `DLS_LANES; l++) begin
        SERIAL_DATA_POS_O[l] <= lane_bit(shreg, l, slot);
        SERIAL_DATA_NEG_O[l] <= !lane_bit(shreg, l, slot);
      end
      fwd <= (state == DLS_RUN) && (slot < `DLS_FWD_HIGH + 3'h2);
    end
  end

  assign FWD_CLOCK_POS_O  = fwd;
  assign FWD_CLOCK_NEG_O  = !fwd;
  assign SERIAL_DATA_OE_O = {`DLS_LANES{sb_s2}};
  assign FWD_CLOCK_OE_O   = sb_s2;
  assign LOCKED_O         = clk_alive;

  a_standby_hiz: assert property (@(posedge CORE_CLK_I)
    !sb_s2 |-> (SERIAL_DATA_OE_O == '0) && !FWD_CLOCK_OE_O)
    else $error("outputs driven in standby");
  a_standby_reset: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    !sb_s2 |=> state == DLS_IDLE && !LOCKED_O)
    else $error("block not held in standby");
  a_rise_capture: assert property (@(posedge CORE_CLK_I) disable iff (blk_rst)
    (sel_s2 && pclk_s2 && !pclk_d) |=> clk_alive)
    else $error("rising edge not captured");
  a_fall_capture: assert property (@(posedge CORE_CLK_I) disable iff (blk_rst)
    (!sel_s2 && !pclk_s2 && pclk_d) |=> clk_alive)
    else $error("falling edge not captured");
  a_diff_pair: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    SERIAL_DATA_NEG_O == ~SERIAL_DATA_POS_O)
    else $error("data pair not complementary");
  a_slot_count: assert property (@(posedge CORE_CLK_I) disable iff (blk_rst)
    (state == DLS_RUN && slot == 3'h0 && !(bq.out_ready && bq.out_valid))
    |=> slot == 3'h1 ##5 slot == 3'h6)
    else $error("slot sequence broken");
  a_fwd_phase: assert property (@(posedge CORE_CLK_I) disable iff (blk_rst)
    (state == DLS_RUN && slot == 3'h1) |=> fwd)
    else $error("forwarded clock phase wrong");
  a_clk_lost: assert property (@(posedge CORE_CLK_I) disable iff (blk_rst)
    (lost_cnt == 8'(LOST_CYC) && !cap_edge) |=> !clk_alive)
    else $error("lost clock not detected");
  a_fwd_pair: assert property (@(posedge CORE_CLK_I)
    FWD_CLOCK_NEG_O == !FWD_CLOCK_POS_O)
    else $error("clock pair not complementary");
  a_first_clock: assert property (@(posedge CORE_CLK_I) disable iff (blk_rst)
    (!clk_alive && cap_edge) |=> clk_alive)
    else $error("late clock not accepted");

  c_word_sent: cover property (@(posedge CORE_CLK_I)
    state == DLS_RUN && slot == 3'h6);
  c_buf_full: cover property (@(posedge CORE_CLK_I) !bq.in_ready);
  c_relock: cover property (@(posedge CORE_CLK_I)
    !clk_alive ##1 clk_alive);
  c_standby: cover property (@(posedge CORE_CLK_I) sb_s2 ##1 !sb_s2);
endmodule
`default_nettype wire

// File: rtl/dls_params.svh
`ifndef DLS_PARAMS_SVH
`define DLS_PARAMS_SVH
`define DLS_WORD_W     21
`define DLS_COLOR_W    6
`define DLS_LANES      3
`define DLS_BITS_LANE  7
`define DLS_BIT_LINE   18
`define DLS_BIT_FRAME  19
`define DLS_BIT_VALID  20
`define DLS_LOST_CYC   64
`define DLS_FWD_HIGH   3'h2
`endif

// File: rtl/dls_pkg.sv
`include "dls_params.svh"
package dls_pkg;
  typedef logic [`DLS_WORD_W-1:0] dls_word_t;
  typedef logic [`DLS_LANES-1:0]  dls_lanes_t;
  typedef enum logic [1:0] {
    DLS_IDLE,
    DLS_RUN
  } dls_state_t;
endpackage

// File: rtl/dls_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dls_buf_if;
  import dls_pkg::*;
  logic      in_valid;
  logic      in_ready;
  dls_word_t in_data;
  logic      out_valid;
  logic      out_ready;
  dls_word_t out_data;
  modport buf_side (input in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// File: rtl/dls_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module dls_buf2 #(
  parameter int DEPTH = 2
) (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  dls_buf_if.buf_side   bus
);
  import dls_pkg::*;
  dls_word_t mem [DEPTH];
  logic [1:0] count;
  logic       wp;
  logic       rp;
  logic       push;
  logic       pop;

  assign bus.in_ready  = (count != 2'(DEPTH));
  assign bus.out_valid = (count != 2'h0);
  assign bus.out_data  = mem[rp];
  assign push = bus.in_valid && bus.in_ready;
  assign pop  = bus.out_valid && bus.out_ready;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 2'h0;
      wp    <= 1'b0;
      rp    <= 1'b0;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      count <= count + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[wp] <= bus.in_data;
  end

  a_buf_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    count <= 2'(DEPTH)) else $error("buffer overflow");
endmodule
`default_nettype wire

// File: testbench/dls_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module dls_rx_model
  import dls_pkg::*;
(
  input  wire logic       clk_i,
  input  wire dls_lanes_t pos_i,
  input  wire logic       fwd_i,
  output dls_word_t       word_o,
  output logic            got_o
);
  logic       fwd_d;
  logic [2:0] n = 3'h7;
  logic [2:0] s;
  dls_word_t  acc;
  dls_word_t  w;
  // Slot 0 is the cycle where the forwarded clock rises; 7 means idle
  always_comb begin
    s = (fwd_i && !fwd_d) ? 3'h0 : n;
    w = acc;
    for (int l = 0; l < 3; l++) begin
      if (s != 3'h7) w[l*7+s] = pos_i[l];
    end
  end
  always_ff @(posedge clk_i) begin
    fwd_d <= fwd_i;
    acc <= w;
    n <= (s == 3'h7 || s == 3'h6) ? 3'h7 : s + 3'h1;
    got_o <= (s == 3'h6);
    if (s == 3'h6) word_o <= w;
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
  import dls_pkg::*;
  logic       clk = 0, rst = 1, sb_n = 1, sel = 0, pix = 0;
  dls_word_t  din = '0, rx_word;
  dls_lanes_t pos, neg, oe;
  logic       fp, fn, foe, locked, rdy, rx_got;
  int         failures = 0, tests_run = 0, cyc = 0;
  dls_word_t  rxq[$];
  dls_serializer #(.LOST_CYC(16)) dut (
    .CORE_CLK_I(clk), .RST_I(rst), .STANDBY_N_I(sb_n),
    .STROBE_EDGE_SELECT_I(sel), .PIXEL_CLOCK_IN_I(pix),
    .PARALLEL_PIXEL_IN_I(din), .IN_READY_O(rdy),
    .SERIAL_DATA_POS_O(pos), .SERIAL_DATA_NEG_O(neg),
    .SERIAL_DATA_OE_O(oe), .FWD_CLOCK_POS_O(fp), .FWD_CLOCK_NEG_O(fn),
    .FWD_CLOCK_OE_O(foe), .LOCKED_O(locked));
  dls_rx_model far (.clk_i(clk), .pos_i(pos), .fwd_i(fp),
                    .word_o(rx_word), .got_o(rx_got));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rx_got === 1'b1) rxq.push_back(rx_word);
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Selected edge at step 0; junk covers the other edge
  task automatic period(input dls_word_t w, input int len = 8);
    for (int k = 0; k < len; k++) begin
      @(negedge clk);
      pix = sel ? (k < len / 2) : (k >= len / 2);
      if (k == 2) din = ~w;
      if (k == len - 2) din = w;
    end
  endtask
  task automatic stream(input dls_word_t a, input dls_word_t b,
                        input int len = 8);
    int i;
    rxq.delete();
    period(a, len);
    period(b, len);
    period(b, len);
    period(b, len);
    i = 0;
    while (i < rxq.size() && rxq[i] !== a) i++;
    `CHK("first", a, (i < rxq.size()) ? rxq[i] : ~a)
    `CHK("second", b, (i + 1 < rxq.size()) ? rxq[i+1] : ~b)
  endtask
  task automatic rising_capture();
    sel = 1'b1;
    stream(21'h1a5c3e, 21'h0f0f0f);
    `CHK("neg", ~pos, neg)
    `CHK("fneg", ~fp, fn)
    `CHK("oe", 3'h7, oe)
    `CHK("rdy", 1'b1, rdy)
  endtask
  task automatic falling_capture();
    sel = 1'b0;
    stream(21'h155555, 21'h0aaaaa);
  endtask
  task automatic standby_then_start();
    sb_n = 1'b0;
    period(21'h000001);
    period(21'h000002);
    `CHK("oe", 3'h0, oe)
    `CHK("foe", 1'b0, foe)
    `CHK("locked", 1'b0, locked)
    sb_n = 1'b1;
    repeat (8) @(negedge clk);
    stream(21'h100000, 21'h0c0003);
  endtask
  task automatic stop_resume();
    repeat (40) @(negedge clk);
    `CHK("lost", 1'b0, locked)
    stream(21'h1fffff, 21'h000000);
  endtask
  // Slightly stretched pixel clock period must still be followed
  task automatic spread_follow();
    stream(21'h03c0f5, 21'h1c3a65, 9);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rising_capture();
    falling_capture();
    standby_then_start();
    stop_resume();
    spread_follow();
    conclude();
  end
endmodule
`default_nettype wire
